// File: fpw_pkg.sv
// package: register map, field layout and pull range table
package fpw_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] FPW_ADDR_LOW = 8'h00;
  localparam logic [7:0] FPW_ADDR_HIGH = 8'h01;
  localparam logic [7:0] FPW_ADDR_RANGE = 8'h02;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int FPW_REG_W = 16;
  localparam int FPW_WORD_W = 26;
  localparam int FPW_LOW_W = 16;
  localparam int FPW_HIGH_W = 10;
  localparam int FPW_HIGH_LSB = 0;
  localparam int FPW_DRV_EN_BIT = 10;
  localparam int FPW_RANGE_W = 4;
  localparam int FPW_RANGE_LSB = 0;
  localparam int FPW_QPPM_W = 15;
  localparam int FPW_SCALED_W = FPW_WORD_W + FPW_QPPM_W;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [FPW_LOW_W-1:0] FPW_LOW_RST = 16'h0000;
  localparam logic [FPW_HIGH_W-1:0] FPW_HIGH_RST = 10'h000;
  localparam logic FPW_DRV_EN_RST = 1'b0;
  localparam logic [FPW_RANGE_W-1:0] FPW_RANGE_RST = 4'h9;
  localparam logic [FPW_REG_W-1:0] FPW_RDATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // pull range limits in quarter ppm, indexed by range code
  // ---------------------------------------------------------------
  localparam logic [FPW_QPPM_W-1:0] FPW_RANGE_QPPM [16] = '{
    15'h0019, 15'h0028, 15'h0032, 15'h0064,
    15'h00C8, 15'h0140, 15'h0190, 15'h01F4,
    15'h0258, 15'h0320, 15'h0640, 15'h0960,
    15'h0C80, 15'h12C0, 15'h1900, 15'h3200
  };

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [FPW_REG_W-1:0] wdata;
  } fpw_req_t;

  typedef struct packed {
    logic rvalid;
    logic [FPW_REG_W-1:0] rdata;
  } fpw_rsp_t;

endpackage

// File: fpw_scaler.sv
// signed pull word scaled against the selected pull range limit
`timescale 1ns/10ps
`default_nettype none
module fpw_scaler import fpw_pkg::*; #(
  parameter int WORD_W = FPW_WORD_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operands
  input wire logic signed [WORD_W-1:0] word,
  input wire logic [FPW_RANGE_W-1:0] range_code,
  // result: word times limit, not normalised; a full scale word gives 2^25 times the limit
  output logic signed [WORD_W+FPW_QPPM_W-1:0] scaled_q
);

  wire logic [FPW_QPPM_W-1:0] limit_qppm;
  wire logic signed [FPW_QPPM_W:0] limit_s;
  wire logic signed [WORD_W+FPW_QPPM_W:0] product;

  assign limit_qppm = FPW_RANGE_QPPM[range_code];
  assign limit_s = signed'({1'b0, limit_qppm});
  assign product = word * limit_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scaled_q <= '0;
    end else begin
      scaled_q <= product[WORD_W+FPW_QPPM_W-1:0];
    end
  end

endmodule // fpw_scaler
`default_nettype wire

// File: fpw_regs.sv
// pull word register pair with drive enable and pull range select
`timescale 1ns/10ps
`default_nettype none
//Function
// - the low register at address 0 holds pull word bits 15..0, all RW.
// - the high register at address 1 holds pull word bits 25..16 in [9:0].
// - reset clears all 26 pull word bits so no offset is applied.
// - the 26-bit pull word is a signed two's-complement value.
// - a new offset is applied only when the high or the range register is written.
// - high register bits 15..11 read as zero and ignore writes.
// - high register bit 10 enables the output driver, reset value 0.
// - the enable bit only acts under software drive enable control.
// - the applied word is scaled against the range field at address 2.
// - registers are reached through the slave register access port.
module fpw_regs import fpw_pkg::*; #(
  parameter logic [FPW_RANGE_W-1:0] RANGE_DEFAULT = FPW_RANGE_RST
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register access from the serial slave engine
  input wire fpw_req_t reg_req,
  output fpw_rsp_t reg_rsp_q,
  // drive enable configuration pins
  input wire logic drive_sw_ctrl,
  input wire logic drive_en_pin,
  // outputs to the oscillator core
  output logic signed [FPW_WORD_W-1:0] pull_word_q,
  output logic pull_update_q,
  output logic [FPW_RANGE_W-1:0] pull_range_q,
  output logic signed [FPW_SCALED_W-1:0] pull_offset_q,
  output logic drive_enable_q
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // meta stage feeds only the second stage
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  wire logic sw_ctrl;
  wire logic pin_en;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {drive_sw_ctrl, drive_en_pin};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign sw_ctrl = pin_sync_q[1];
  assign pin_en = pin_sync_q[0];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic wr_low;
  wire logic wr_high;
  wire logic wr_range;

  assign wr_low = reg_req.wr && (reg_req.addr == FPW_ADDR_LOW);
  assign wr_high = reg_req.wr && (reg_req.addr == FPW_ADDR_HIGH);
  assign wr_range = reg_req.wr && (reg_req.addr == FPW_ADDR_RANGE);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [FPW_LOW_W-1:0] low_q;
  logic [FPW_HIGH_W-1:0] high_q;
  logic drv_bit_q;
  wire logic [FPW_LOW_W-1:0] low_d;
  wire logic [FPW_HIGH_W-1:0] high_d;
  wire logic drv_bit_d;
  wire logic [FPW_RANGE_W-1:0] range_d;

  assign low_d = wr_low ? reg_req.wdata : low_q;
  assign high_d = wr_high ?
    reg_req.wdata[FPW_HIGH_LSB +: FPW_HIGH_W] : high_q;
  // bits 15..11 have no storage, so writes there vanish
  assign drv_bit_d = wr_high ?
    reg_req.wdata[FPW_DRV_EN_BIT] : drv_bit_q;
  assign range_d = wr_range ?
    reg_req.wdata[FPW_RANGE_LSB +: FPW_RANGE_W] : pull_range_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= FPW_LOW_RST;
      high_q <= FPW_HIGH_RST;
      drv_bit_q <= FPW_DRV_EN_RST;
      pull_range_q <= RANGE_DEFAULT;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
      drv_bit_q <= drv_bit_d;
      pull_range_q <= range_d;
    end
  end

  // ---------------------------------------------------------------
  // applied pull word
  // ---------------------------------------------------------------
  // low writes alone never move the frequency; host orders low first
  wire logic signed [FPW_WORD_W-1:0] word_d;

  assign word_d = wr_high ?
    signed'({reg_req.wdata[FPW_HIGH_LSB +: FPW_HIGH_W], low_q}) :
    pull_word_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_word_q <= '0;
      pull_update_q <= 1'b0;
    end else begin
      pull_word_q <= word_d;
      pull_update_q <= wr_high;
    end
  end

  fpw_scaler #(
    .WORD_W(FPW_WORD_W)
  ) u_scaler (
    .clk(ref_clk),
    .rst_n(rst_n),
    .word(pull_word_q),
    .range_code(pull_range_q),
    .scaled_q(pull_offset_q)
  );

  // ---------------------------------------------------------------
  // output driver enable
  // ---------------------------------------------------------------
  // under pin control the stored bit still reads back but is not used
  wire logic drive_d;

  assign drive_d = sw_ctrl ? drv_bit_q : pin_en;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_enable_q <= 1'b0;
    end else begin
      drive_enable_q <= drive_d;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [FPW_REG_W-1:0] rdata_sel;

  always_comb begin
    rdata_sel = FPW_RDATA_RST;
    case (reg_req.addr)
      FPW_ADDR_LOW: begin
        rdata_sel = low_q;
      end
      FPW_ADDR_HIGH: begin
        rdata_sel[FPW_HIGH_LSB +: FPW_HIGH_W] = high_q;
        rdata_sel[FPW_DRV_EN_BIT] = drv_bit_q;
      end
      FPW_ADDR_RANGE: begin
        rdata_sel[FPW_RANGE_LSB +: FPW_RANGE_W] = pull_range_q;
      end
      default: begin
        rdata_sel = FPW_RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp_q <= '0;
    end else begin
      reg_rsp_q.rvalid <= reg_req.rd;
      reg_rsp_q.rdata <= reg_req.rd ? rdata_sel : FPW_RDATA_RST;
    end
  end

endmodule // fpw_regs
`default_nettype wire

// File: fpw_regs_monitor.sv
// checker for the pull word register pair
`timescale 1ns/10ps
`default_nettype none
module fpw_regs_monitor import fpw_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire fpw_req_t reg_req,
  input wire fpw_rsp_t reg_rsp_q,
  // pins and outputs
  input wire logic drive_sw_ctrl,
  input wire logic drive_en_pin,
  input wire logic signed [FPW_WORD_W-1:0] pull_word_q,
  input wire logic pull_update_q,
  input wire logic [FPW_RANGE_W-1:0] pull_range_q,
  input wire logic signed [FPW_SCALED_W-1:0] pull_offset_q,
  input wire logic drive_enable_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic hi_wr = reg_req.wr && reg_req.addr == FPW_ADDR_HIGH;
  wire logic rg_wr = reg_req.wr && reg_req.addr == FPW_ADDR_RANGE;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  upd_on_high_a: assert property (hi_wr |=> pull_update_q)
    else $error("no update after high write");
  upd_cause_a: assert property (pull_update_q |-> $past(hi_wr))
    else $error("update without high write");
  word_hold_a: assert property (!pull_update_q |-> $stable(pull_word_q))
    else $error("pull word moved without update");
  word_load_a: assert property (hi_wr |=>
    pull_word_q[25:16] == $past(reg_req.wdata[9:0]))
    else $error("high bits not loaded");
  rd_pulse_a: assert property (reg_req.rd |=> reg_rsp_q.rvalid)
    else $error("read not answered");
  rd_cause_a: assert property (reg_rsp_q.rvalid |-> $past(reg_req.rd))
    else $error("answer without read");
  hi_pad_a: assert property (reg_req.rd &&
    reg_req.addr == FPW_ADDR_HIGH |=> reg_rsp_q.rdata[15:11] == 5'h00)
    else $error("unused high bits not zero");
  range_load_a: assert property (rg_wr |=>
    pull_range_q == $past(reg_req.wdata[3:0]))
    else $error("range code not loaded");
  pin_ctrl_a: assert property ((!drive_sw_ctrl &&
    $stable(drive_en_pin))[*6] |-> drive_enable_q == drive_en_pin)
    else $error("pin control not followed");
  sw_ctrl_a: assert property (drive_sw_ctrl[*6] ##0 hi_wr |->
    ##2 drive_enable_q == $past(reg_req.wdata[10], 2))
    else $error("drive bit not applied");
  cover property (hi_wr);
  cover property (reg_rsp_q.rvalid);
  cover property (!drive_sw_ctrl && drive_enable_q);
endmodule // fpw_regs_monitor
bind fpw_regs fpw_regs_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn),
  .reg_req(reg_req), .reg_rsp_q(reg_rsp_q), .drive_sw_ctrl(drive_sw_ctrl),
  .drive_en_pin(drive_en_pin), .pull_word_q(pull_word_q),
  .pull_update_q(pull_update_q), .pull_range_q(pull_range_q),
  .pull_offset_q(pull_offset_q), .drive_enable_q(drive_enable_q));
`default_nettype wire

// File: fpw_host_model.sv
// register port host standing in for the serial bus master
`timescale 1ns/10ps
`default_nettype none
module fpw_host_model import fpw_pkg::*; #(
  parameter int GAP = 2632
) (
  // register port
  input wire logic ref_clk,
  output var fpw_req_t reg_req,
  input wire fpw_rsp_t reg_rsp_q
);
  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  initial reg_req = '0;
  // idle port shows inverted address and data, never the last request
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [FPW_REG_W-1:0] d, output fpw_rsp_t r);
    if (w && a == FPW_ADDR_HIGH) begin
      repeat (GAP) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    #1;
    reg_req = '{w, !w, a, d};
    @(posedge ref_clk);
    #1;
    reg_req = '{1'b0, 1'b0, ~reg_req.addr, ~reg_req.wdata};
    r = reg_rsp_q;
  endtask
endmodule // fpw_host_model
`default_nettype wire

// File: tb_fpw_regs.sv
// testbench for the pull word register pair
`timescale 1ns/10ps
`default_nettype none
module tb_fpw_regs import fpw_pkg::*;;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic drive_sw_ctrl = 1'b1;
  logic drive_en_pin = 1'b1;
  fpw_req_t reg_req;
  fpw_rsp_t reg_rsp_q;
  fpw_rsp_t rsp;
  logic signed [FPW_WORD_W-1:0] pull_word_q;
  logic pull_update_q;
  logic drive_enable_q;
  logic [FPW_RANGE_W-1:0] pull_range_q;
  logic signed [FPW_SCALED_W-1:0] pull_offset_q;
  int mismatches = 0;
  int checks_done = 0;
  initial forever #5 ref_clk = ~ref_clk;
  fpw_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rsp_q(reg_rsp_q), .drive_sw_ctrl(drive_sw_ctrl),
    .drive_en_pin(drive_en_pin), .pull_word_q(pull_word_q),
    .pull_update_q(pull_update_q), .pull_range_q(pull_range_q),
    .pull_offset_q(pull_offset_q), .drive_enable_q(drive_enable_q));
  // short update spacing keeps the run brief
  fpw_host_model #(.GAP(8)) u_host (.ref_clk(ref_clk), .reg_req(reg_req),
    .reg_rsp_q(reg_rsp_q));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, rsp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_host.xfer(1'b0, a, 16'h0000, rsp);
    chk({40'h0, rsp.rvalid}, 41'h1);
    chk(rsp.rdata, e);
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    edges(6);
    resetn = 1'b1;
    edges(2);
    chk({15'h0, pull_word_q}, 41'h0);
    chk({37'h0, pull_range_q}, {37'h0, FPW_RANGE_RST});
    chk({40'h0, drive_enable_q}, 41'h0);
    rd(FPW_ADDR_LOW, 16'h0000);
    rd(FPW_ADDR_HIGH, 16'h0000);
    wr(FPW_ADDR_LOW, 16'h6666);
    chk({40'h0, pull_update_q}, 41'h0);
    chk({15'h0, pull_word_q}, 41'h0);
    wr(FPW_ADDR_HIGH, 16'hFFE6);
    chk({40'h0, pull_update_q}, 41'h1);
    chk({15'h0, pull_word_q}, 41'h3E66666);
    chk({40'h0, pull_word_q < 0}, 41'h1);
    rd(FPW_ADDR_LOW, 16'h6666);
    rd(FPW_ADDR_HIGH, 16'h07E6);
    chk({40'h0, drive_enable_q}, 41'h1);
    rd(8'h05, 16'h0000);
    wr(FPW_ADDR_RANGE, 16'hFFF3);
    rd(FPW_ADDR_RANGE, 16'h0003);
    chk({37'h0, pull_range_q}, 41'h3);
    wr(FPW_ADDR_HIGH, 16'h0000);
    chk({15'h0, pull_word_q}, 41'h6666);
    edges(1);
    chk(pull_offset_q, 41'h6666 * FPW_RANGE_QPPM[3]);
    chk({40'h0, pull_update_q}, 41'h0);
    // stored bit is 0 here, so a high enable proves the pin took over
    drive_sw_ctrl = 1'b0;
    edges(3);
    chk({40'h0, drive_enable_q}, 41'h1);
    drive_en_pin = 1'b0;
    wr(FPW_ADDR_HIGH, 16'h0400);
    edges(2);
    chk({40'h0, drive_enable_q}, 41'h0);
    drive_en_pin = 1'b1;
    edges(3);
    chk({40'h0, drive_enable_q}, 41'h1);
    stop_test();
  end
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule // tb_fpw_regs
`default_nettype wire
